// File: rtl/cch_pkg.sv
// Constants, carriers and states of the chain command handler.
package cch_pkg;

  // Command and response codes.
  localparam logic [7:0] CMD_ROLL  = 8'hD0;
  localparam logic [7:0] CMD_NAK   = 8'hD1;
  localparam logic [7:0] CMD_ACK   = 8'hD2;
  localparam logic [7:0] CMD_FAIL  = 8'hD3;
  localparam logic [7:0] CMD_WAKE  = 8'hD5;
  localparam logic [7:0] CMD_SOFT  = 8'hD6;
  localparam logic [7:0] CMD_CKSET = 8'hD7;
  localparam logic [7:0] CMD_CKCMP = 8'hD8;
  localparam logic [7:0] CMD_OVR   = 8'hDA;
  localparam logic [7:0] CMD_PRE   = 8'hDE;
  localparam logic [7:0] CMD_HARD  = 8'hDF;

  // Chain addresses.
  localparam logic [5:0] ADDR_ALL    = 6'h00;
  localparam logic [5:0] ADDR_MASTER = 6'h01;

  // Timing.
  localparam int CLK_HZ      = 100_000_000;
  localparam int CLK_NS      = 10;
  localparam int WAKE_HZ     = 4_000;
  localparam int HRST_HZ     = 32_000;
  localparam int HRST_HALF   = CLK_HZ / (2 * HRST_HZ);
  localparam int ACK_NS      = 1_000;
  localparam int ACK_GAP     = ACK_NS / CLK_NS;
  localparam int ACK_CLKS    = 8;
  localparam int COMMS_US    = 1_000;
  localparam int PKT_US      = 1_000;
  localparam int TONE_CYCLES = 16;

  // Fault bits that an override write may clear but never set.
  localparam int FB_OV  = 0;
  localparam int FB_UV  = 1;
  localparam int FB_OT  = 2;
  localparam int FB_OW  = 3;
  localparam int FB_PAR = 4;
  localparam int FB_BUF = 5;
  localparam logic [15:0] FW_LOCK = 16'((1 << FB_OV) | (1 << FB_UV) |
    (1 << FB_OT) | (1 << FB_OW) | (1 << FB_PAR) | (1 << FB_BUF));

  // Decoded command and outgoing answer.
  typedef struct packed {
    logic [7:0] code;
    logic [5:0] addr;
    logic [3:0] frame;
    logic       crc_ok;
    logic       rd;
    logic       wr;
    logic       bad_reg;
  } cch_cmd_s;

  typedef struct packed {
    logic [7:0] code;
    logic [5:0] addr;
    logic [3:0] frame;
  } cch_resp_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_TONE = 2'b10,
    ST_SRST = 2'b11
  } cch_state_e;

endpackage

// File: rtl/cch_chain_command_handler.sv
// Chain command handler: enumeration, answers, tones, resets, checksums.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Enumeration may come any time; host sends it after power-up and resets.
// - Top device answers enumeration with its address and frame count plus one.
// - Any command from below but a good enumeration ends enumeration mode at once.
// - Enumeration accepted at any address; bad CRC means no action.
// - Device is top when its address equals the stack size field.
// - Bad CRC enumeration is ignored; no valid reply above makes us top.
// - Master answers a bad-CRC enumeration with a negative acknowledge.
// - Non-master sends eight clocks down; fewer received means act as top.
// - Top's enumeration reply is relayed down unchanged, errors or not.
// - Acknowledge to an unheld address is answered by the top device.
// - Commands that cannot execute get a negative acknowledge.
// - Acknowledge and writes get acknowledge; chain failure gives failing position.
// - No reply from above within timeout sends communications failure down.
// - Wakeup after prefix makes master drive a 4kHz tone onto the chain.
// - Soft restart restores defaults, stops scans, waits packet timeout, resets.
// - D7H stores a register checksum; D8H recomputes and compares it.
// - All ones clears faults; after override the next write replaces data.
// - Prefix to master arms trap; other addresses or trapped commands refused.
// - Prefix refused while addresses unassigned; no answer while asleep.
// - Broadcast hard restart after prefix drives 32kHz tone; others refused.
// - Broadcast wakeup answered by master only; targeted wakeup refused; non-masters here answer it with a negative acknowledge.
module cch_chain_command_handler #(
  parameter int COMMS_CYC = cch_pkg::COMMS_US * (cch_pkg::CLK_HZ / 1_000_000),
  parameter int PKT_CYC   = cch_pkg::PKT_US * (cch_pkg::CLK_HZ / 1_000_000),
  parameter int WAKE_HALF = cch_pkg::CLK_HZ / (2 * cch_pkg::WAKE_HZ)
) (
  // Clock and reset.
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Command from the lower port or SPI.
  input  wire logic              cmd_valid,
  input  wire cch_pkg::cch_cmd_s cmd,
  // Traffic from the device above.
  input  wire logic              reply_valid,
  input  wire cch_pkg::cch_resp_s reply,
  input  wire logic              ack_clk_in,
  // Device status.
  input  wire logic              is_master,
  input  wire logic              asleep,
  input  wire logic              addr_assigned,
  input  wire logic [5:0]        my_addr,
  input  wire logic [5:0]        stack_size,
  // Fault register write merge.
  input  wire logic              fw_commit,
  input  wire logic [15:0]       fw_old,
  input  wire logic [15:0]       fw_data,
  output logic [15:0]            fw_new,
  output logic                   ovr_armed,
  // Answers and relays.
  output logic                   resp_valid,
  output cch_pkg::cch_resp_s     resp,
  output logic                   relay_up,
  output logic                   relay_down,
  output logic                   ack_clk_out,
  // Chain signalling and device actions.
  output logic                   chain_tone,
  output logic                   hard_reset,
  output logic                   regs_default,
  output logic                   scan_stop,
  output logic                   self_reset,
  output logic                   cksum_calc,
  output logic                   cksum_check,
  output logic                   rc_mode,
  output logic                   top_dev,
  output logic                   trap
);
  import cch_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  cch_state_e  st;
  logic [23:0] tmr;
  logic [5:0]  tone_n;
  logic        tone_hard;
  logic        wait_rc;
  logic        rc_top;
  logic [3:0]  rc_frame;
  logic [3:0]  ack_cnt;
  logic [3:0]  ack_left;
  logic [7:0]  gap;
  logic        ack_go;

  // Builds an answer frame.
  function automatic cch_resp_s mk(logic [7:0] c, logic [5:0] a,
                                   logic [3:0] f);
    cch_resp_s r;
    r.code  = c;
    r.addr  = a;
    r.frame = f;
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  // Read and write frames carry no command code of their own.
  wire logic rw       = cmd.rd || cmd.wr;
  wire logic c_roll   = !rw && (cmd.code == CMD_ROLL);
  wire logic c_ack    = !rw && (cmd.code == CMD_ACK);
  wire logic c_wake   = !rw && (cmd.code == CMD_WAKE);
  wire logic c_soft   = !rw && (cmd.code == CMD_SOFT);
  wire logic c_ckset  = !rw && (cmd.code == CMD_CKSET);
  wire logic c_ckcmp  = !rw && (cmd.code == CMD_CKCMP);
  wire logic c_ovr    = !rw && (cmd.code == CMD_OVR);
  wire logic c_pre    = !rw && (cmd.code == CMD_PRE);
  wire logic c_hard   = !rw && (cmd.code == CMD_HARD);
  wire logic for_me   = (cmd.addr == my_addr);
  wire logic bcast    = (cmd.addr == ADDR_ALL);
  wire logic idle_cmd = cmd_valid && (st == ST_IDLE);
  wire logic good     = idle_cmd && !trap && cmd.crc_ok;
  wire logic c_bc_ok  = c_ckset || c_ckcmp || c_ovr;
  wire logic c_resp   = rw || c_ack || c_bc_ok;
  wire logic acting   = for_me || (bcast && c_bc_ok);

  // Timer end points.
  wire logic to_over   = (tmr == 24'(COMMS_CYC - 1));
  wire logic pkt_over  = (tmr == 24'(PKT_CYC - 1));
  wire logic half_over = tone_hard ? (tmr == 24'(HRST_HALF - 1))
                                   : (tmr == 24'(WAKE_HALF - 1));
  wire logic ack_ok    = (ack_cnt >= 4'(ACK_CLKS));
  wire logic tone_end  = (tone_n == 6'(2 * TONE_CYCLES - 1));

  // ---------------------------------------------------------------
  // Main sequencer
  // ---------------------------------------------------------------
  // Handles each command in idle, waits for the chain, drives tones.
  always_ff @(posedge ref_clk) begin
    resp_valid   <= 1'b0;
    relay_up     <= 1'b0;
    relay_down   <= 1'b0;
    hard_reset   <= 1'b0;
    regs_default <= 1'b0;
    scan_stop    <= 1'b0;
    self_reset   <= 1'b0;
    cksum_calc   <= 1'b0;
    cksum_check  <= 1'b0;
    ack_go       <= 1'b0;
    if (rst) begin
      st         <= ST_IDLE;
      tmr        <= 24'h000000;
      tone_n     <= 6'h00;
      tone_hard  <= 1'b0;
      wait_rc    <= 1'b0;
      rc_top     <= 1'b0;
      rc_frame   <= 4'h0;
      ack_cnt    <= 4'h0;
      trap       <= 1'b0;
      chain_tone <= 1'b0;
      resp       <= '0;
    end else begin
      case (st)
        ST_IDLE: begin
          tmr <= 24'h000000;
          if (cmd_valid && trap) begin
            trap <= 1'b0;
            if (cmd.crc_ok && bcast && (c_wake || c_hard)) begin
              st        <= ST_TONE;
              tone_hard <= c_hard;
              tone_n    <= 6'h00;
              resp       <= mk(CMD_ACK, my_addr, 4'h0);
              resp_valid <= c_wake;
            end else begin
              resp       <= mk(CMD_NAK, my_addr, 4'h0);
              resp_valid <= 1'b1;
            end
          end else if (cmd_valid && !cmd.crc_ok) begin
            // A silent refusal leaves the held answer untouched as well.
            if (!c_roll || is_master) begin
              resp       <= mk(CMD_NAK, my_addr, 4'h0);
              resp_valid <= 1'b1;
            end
          end else if (cmd_valid && c_roll) begin
            relay_up <= 1'b1;
            st       <= ST_WAIT;
            wait_rc  <= 1'b1;
            ack_cnt  <= 4'h0;
            rc_top   <= 1'b0;
            rc_frame <= cmd.frame;
            ack_go   <= !is_master;
          end else if (cmd_valid && c_pre) begin
            if (is_master && !asleep) begin
              trap <= (cmd.addr == ADDR_MASTER) && addr_assigned;
              resp <= ((cmd.addr == ADDR_MASTER) && addr_assigned)
                      ? mk(CMD_ACK, my_addr, 4'h0)
                      : mk(CMD_NAK, my_addr, 4'h0);
              resp_valid <= 1'b1;
            end
          end else if (cmd_valid && (c_wake || c_hard)) begin
            resp       <= mk(CMD_NAK, my_addr, 4'h0);
            resp_valid <= 1'b1;
          end else if (cmd_valid && c_soft) begin
            if (for_me || bcast) begin
              regs_default <= 1'b1;
              scan_stop    <= 1'b1;
              st           <= ST_SRST;
            end
          end else if (cmd_valid && c_resp) begin
            cksum_calc  <= acting && c_ckset;
            cksum_check <= acting && c_ckcmp;
            if (bcast && !c_bc_ok) begin
              resp       <= mk(CMD_NAK, my_addr, 4'h0);
              resp_valid <= 1'b1;
            end else if (for_me || top_dev) begin
              resp       <= mk(cmd.bad_reg ? CMD_NAK : CMD_ACK,
                               my_addr, 4'h0);
              resp_valid <= 1'b1;
            end else begin
              relay_up <= 1'b1;
              st       <= ST_WAIT;
              wait_rc  <= 1'b0;
            end
          end else if (cmd_valid) begin
            relay_up <= !top_dev;
          end
        end
        ST_WAIT: begin
          tmr <= tmr + 24'h000001;
          if (ack_clk_in && !ack_ok) begin
            ack_cnt <= ack_cnt + 4'h1;
          end
          if (reply_valid && (!wait_rc || ack_ok)) begin
            st <= ST_IDLE;
            if (is_master && !wait_rc && reply.code == CMD_FAIL) begin
              resp       <= mk(CMD_NAK, reply.addr, 4'h0);
              resp_valid <= 1'b1;
            end else begin
              relay_down <= 1'b1;
            end
          end else if (to_over) begin
            st         <= ST_IDLE;
            resp_valid <= 1'b1;
            rc_top     <= wait_rc;
            resp       <= wait_rc
                          ? mk(CMD_ROLL, my_addr, rc_frame + 4'h1)
                          : mk(CMD_FAIL, my_addr, 4'h0);
          end
        end
        ST_TONE: begin
          tmr <= tmr + 24'h000001;
          if (half_over) begin
            tmr        <= 24'h000000;
            chain_tone <= !chain_tone;
            tone_n     <= tone_n + 6'h01;
            if (tone_end) begin
              st         <= ST_IDLE;
              hard_reset <= tone_hard;
            end
          end
        end
        ST_SRST: begin
          tmr <= tmr + 24'h000001;
          if (pkt_over) begin
            st         <= ST_IDLE;
            self_reset <= 1'b1;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Side state
  // ---------------------------------------------------------------
  // Emits the burst of acknowledge clocks toward the device below.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_left    <= 4'h0;
      gap         <= 8'h00;
      ack_clk_out <= 1'b0;
    end else begin
      ack_clk_out <= (ack_left != 4'h0) && (gap == 8'(ACK_GAP - 1));
      if (ack_go) begin
        ack_left <= 4'(ACK_CLKS);
        gap      <= 8'h00;
      end else if (ack_left != 4'h0) begin
        gap <= (gap == 8'(ACK_GAP - 1)) ? 8'h00 : gap + 8'h01;
        if (gap == 8'(ACK_GAP - 1)) begin
          ack_left <= ack_left - 4'h1;
        end
      end
    end
  end

  // Enumeration mode, top flag and the override arm; set wins over clear.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rc_mode   <= 1'b0;
      top_dev   <= 1'b0;
      ovr_armed <= 1'b0;
      fw_new    <= 16'h0000;
    end else begin
      if (good && c_roll) begin
        rc_mode <= 1'b1;
      end else if (cmd_valid) begin
        rc_mode <= 1'b0;
      end
      top_dev <= addr_assigned ? (my_addr == stack_size) : rc_top;
      if (fw_commit) begin
        ovr_armed <= 1'b0;
        fw_new    <= ovr_armed ? (fw_data & (~FW_LOCK | fw_old))
                   : (&fw_data ? 16'h0000 : fw_old);
      end
      if (good && c_ovr && (for_me || bcast)) begin
        ovr_armed <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_rc_badcrc_nak;
    idle_cmd && !trap && c_roll && !cmd.crc_ok && is_master
      |=> resp_valid && resp.code == CMD_NAK && !relay_up;
  endproperty
  a_rc_badcrc_nak: assert property (p_rc_badcrc_nak)
    else $error("bad enumeration at master not refused");

  property p_rc_badcrc_quiet;
    idle_cmd && !trap && c_roll && !cmd.crc_ok && !is_master
      |=> !resp_valid && !relay_up && st == ST_IDLE;
  endproperty
  a_rc_badcrc_quiet: assert property (p_rc_badcrc_quiet)
    else $error("bad enumeration acted upon");

  property p_pre_unassigned;
    idle_cmd && !trap && c_pre && cmd.crc_ok && is_master && !asleep
      && !addr_assigned |=> resp_valid && resp.code == CMD_NAK && !trap;
  endproperty
  a_pre_unassigned: assert property (p_pre_unassigned)
    else $error("prefix accepted without addresses");

  property p_trap_other;
    idle_cmd && trap && !(c_wake || c_hard)
      |=> resp.code == CMD_NAK && !relay_up ##1 st == ST_IDLE;
  endproperty
  a_trap_other: assert property (p_trap_other)
    else $error("trapped command not refused");

  property p_hard_tone;
    idle_cmd && trap && cmd.crc_ok && bcast && c_hard
      |=> st == ST_TONE && !resp_valid ##1 $stable(chain_tone);
  endproperty
  a_hard_tone: assert property (p_hard_tone)
    else $error("hard restart tone not started");

  property p_ack_burst;
    good && c_roll && !is_master |-> ##[2:1000] ack_clk_out;
  endproperty
  a_ack_burst: assert property (p_ack_burst)
    else $error("acknowledge clocks not sent");

  property p_ovr_merge;
    fw_commit && ovr_armed && !(good && c_ovr)
      |=> !ovr_armed && fw_new == ($past(fw_data) & (~FW_LOCK | $past(fw_old)));
  endproperty
  a_ovr_merge: assert property (p_ovr_merge)
    else $error("override write merged wrongly");

  property p_wake_target;
    idle_cmd && trap && cmd.crc_ok && c_wake && !bcast
      |=> resp_valid && resp.code == CMD_NAK && st == ST_IDLE;
  endproperty
  a_wake_target: assert property (p_wake_target)
    else $error("targeted wakeup not refused");

  property p_rc_exit;
    cmd_valid && rc_mode && !c_roll |=> !rc_mode;
  endproperty
  a_rc_exit: assert property (p_rc_exit)
    else $error("enumeration mode kept after traffic");

endmodule

`default_nettype wire

// File: bench/cch_chain_partner.sv
// Model of the chain device above: acknowledge clocks and a reply.
`timescale 1ns/10ps
`default_nettype none
module cch_chain_partner (
  // Clock, reset and behaviour select.
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic [1:0]         mode,
  // Traffic to and from the block.
  input  wire logic               relay_up,
  output var  logic               reply_valid,
  output var  cch_pkg::cch_resp_s reply,
  output var  logic               ack_clk_in
);
  import cch_pkg::*;
  int         cnt;
  logic [3:0] n_ack;
  logic [5:0] due;

  // Mode 0 is silent, 1 prompt, 2 short clock burst, 3 slow failure reply.
  assign n_ack = (mode == 2'h2) ? 4'h3 : 4'h8;
  assign due   = (mode == 2'h3) ? 6'h2D : 6'h24;

  // Counts from a relayed command, clocks every 4 cycles, then replies.
  always_ff @(posedge ref_clk) begin
    ack_clk_in  <= 1'b0;
    reply_valid <= 1'b0;
    reply       <= ~reply; // A released line never holds its value.
    if (rst) begin
      cnt   <= 0;
      reply <= '0;
    end else if (relay_up) begin
      cnt <= 1;
    end else if (cnt != 0 && mode != 2'h0) begin
      cnt        <= (cnt == int'(due)) ? 0 : cnt + 1;
      ack_clk_in <= (cnt % 4 == 0) && (cnt / 4 <= int'(n_ack));
      if (cnt == int'(due)) begin
        reply_valid <= 1'b1;
        reply       <= '{code: (mode == 2'h3) ? CMD_FAIL : CMD_ROLL,
                         addr: 6'h0A, frame: 4'h5};
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/cch_chain_command_handler_tb.sv
// Self-checking testbench of the chain command handler.
`timescale 1ns/10ps
`default_nettype none
module cch_chain_command_handler_tb;
  import cch_pkg::*;
  localparam int PC = 50;
  logic       ref_clk = 1'b0;
  logic       rst, cmd_valid, is_master, asleep, addr_assigned, fw_commit;
  logic       ovr_armed, resp_valid, relay_up, relay_down, ack_clk_out;
  logic       chain_tone, hard_reset, regs_default, scan_stop, self_reset;
  logic       cksum_calc, cksum_check, rc_mode, top_dev, trap;
  logic       reply_valid, ack_clk_in, tone_q;
  logic [1:0] mode;
  logic [1:0] ml [3] = '{2'h1, 2'h0, 2'h2};
  logic [3:0] fr;
  logic [5:0] my_addr, stack_size, a;
  logic [15:0] fw_old, fw_data, fw_new, o, d;
  logic [10:0] ev;
  cch_cmd_s   cmd;
  cch_resp_s  resp, reply, last;
  int         cnt [11];
  int         cyc, t_take, t_resp, miscompares, n_compared;

  cch_chain_command_handler #(.COMMS_CYC(50), .PKT_CYC(PC), .WAKE_HALF(20))
    uut (.ref_clk, .rst, .cmd_valid, .cmd, .reply_valid, .reply,
         .ack_clk_in, .is_master, .asleep, .addr_assigned, .my_addr,
         .stack_size, .fw_commit, .fw_old, .fw_data, .fw_new, .ovr_armed,
         .resp_valid, .resp, .relay_up, .relay_down, .ack_clk_out,
         .chain_tone, .hard_reset, .regs_default, .scan_stop, .self_reset,
         .cksum_calc, .cksum_check, .rc_mode, .top_dev, .trap);
  cch_chain_partner far (.ref_clk, .rst, .mode, .relay_up, .reply_valid,
                         .reply, .ack_clk_in);

  // Free-running clock.
  always #5 ref_clk = ~ref_clk;

  // Counts output pulses and tone edges, keeps the latest answer.
  assign ev = {chain_tone ^ tone_q, cksum_check, cksum_calc, self_reset,
               scan_stop, regs_default, hard_reset, ack_clk_out, relay_down,
               relay_up, resp_valid};
  always @(posedge ref_clk) begin
    cyc    <= cyc + 1;
    tone_q <= chain_tone;
    for (int i = 0; i < 11; i++) begin
      if (ev[i] === 1'b1) cnt[i]++;
    end
    if (resp_valid === 1'b1) begin
      last = resp;
      if (t_resp < 0) t_resp = cyc;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Compares one value and counts the result.
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // Sends one command with a random frame, then lets n cycles pass.
  task automatic run(input logic [7:0] c, input logic [5:0] ad,
                     input logic k, input logic [2:0] rwb, input int n);
    @(negedge ref_clk);
    foreach (cnt[i]) cnt[i] = 0;
    t_resp = -1;
    fr = 4'($urandom);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd <= '{code: c, addr: ad, frame: fr, crc_ok: k, rd: rwb[2],
             wr: rwb[1], bad_reg: rwb[0]};
    @(posedge ref_clk);
    t_take = cyc;
    cmd_valid <= 1'b0;
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Checks the number and code of answers; zero means silence.
  task automatic rsp(input logic [7:0] e);
    chk("resp_count", cnt[0], 32'(e != 8'h00));
    if (e != 8'h00) chk("resp_code", last.code, e);
  endtask

  // Prefix followed by a second command, both with good check codes.
  task automatic pw(input logic [5:0] pa, input logic [7:0] nc,
                    input logic [5:0] na, input logic [7:0] e1, e2,
                    input int n);
    run(CMD_PRE, pa, 1'b1, 3'b000, 3);
    rsp(e1);
    if (e1 != 8'h00) chk("pre_latency", t_resp - t_take, 1);
    chk("trap", trap, 32'(e1 == CMD_ACK));
    run(nc, na, 1'b1, 3'b000, n);
    rsp(e2);
    chk("relay_up", cnt[1], 0);
    chk("tone", cnt[10], (e2 == CMD_ACK || (nc == CMD_HARD && e2 == 8'h00))
        ? 2 * TONE_CYCLES : 0);
    chk("hard", cnt[4], 32'(nc == CMD_HARD && e2 == 8'h00));
  endtask

  // Fault register merge expected from old value and written data.
  function automatic logic [15:0] fexp(input logic arm,
                                       input logic [15:0] ov, dv);
    if (arm) return dv & (~FW_LOCK | ov);
    return (&dv) ? 16'h0000 : ov;
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Master first, then a stack device, then local actions.
  initial begin
    void'($urandom(32'h5D5A));
    {rst, is_master, addr_assigned} = 3'b111;
    {cmd_valid, asleep, fw_commit} = 3'b000;
    {cmd, fw_old, fw_data, mode} = '0;
    my_addr = ADDR_MASTER;
    stack_size = 6'h03;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk("reset", {resp, resp_valid, chain_tone, trap, rc_mode}, 0);
    pw(ADDR_MASTER, CMD_WAKE, ADDR_ALL, CMD_ACK, CMD_ACK, 700);
    pw(6'h05, CMD_WAKE, ADDR_ALL, CMD_NAK, CMD_NAK, 5);
    pw(ADDR_MASTER, CMD_ACK, 6'h03, CMD_ACK, CMD_NAK, 5);
    pw(ADDR_MASTER, CMD_WAKE, 6'h07, CMD_ACK, CMD_NAK, 5);
    pw(ADDR_MASTER, CMD_HARD, 6'h05, CMD_ACK, CMD_NAK, 5);
    @(posedge ref_clk);
    addr_assigned <= 1'b0;
    pw(ADDR_MASTER, CMD_WAKE, ADDR_ALL, CMD_NAK, CMD_NAK, 5);
    @(posedge ref_clk);
    {addr_assigned, asleep} <= 2'b11;
    run(CMD_PRE, ADDR_MASTER, 1'b1, 3'b000, 5);
    rsp(8'h00);
    @(posedge ref_clk);
    asleep <= 1'b0;
    run(CMD_ROLL, 6'h09, 1'b0, 3'b000, 5);
    rsp(CMD_NAK);
    pw(ADDR_MASTER, CMD_HARD, ADDR_ALL, CMD_ACK, 8'h00, 50100);
    @(posedge ref_clk);
    mode <= 2'h3;
    run(CMD_ACK, 6'h05, 1'b1, 3'b000, 60);
    rsp(CMD_NAK);
    chk("fail_pos", last.addr, 6'h0A);
    @(posedge ref_clk);
    {is_master, my_addr, stack_size} <= {1'b0, 6'h02, 6'h05};
    run(CMD_ACK, 6'h03, 1'b0, 3'b000, 3);
    rsp(CMD_NAK);
    run(8'h00, 6'h02, 1'b1, 3'b011, 3);
    rsp(CMD_NAK);
    run(CMD_ROLL, 6'h03, 1'b0, 3'b000, 60);
    rsp(8'h00);
    chk("relay_up", cnt[1], 0);
    foreach (ml[j]) begin
      @(posedge ref_clk);
      mode <= ml[j];
      run(CMD_ROLL, 6'($urandom), 1'b1, 3'b000, 2);
      chk("rc_mode", rc_mode, 1);
      repeat (1000) @(posedge ref_clk);
      #1;
      chk("relay_up", cnt[1], 1);
      chk("ack_out", cnt[3], ACK_CLKS);
      chk("relay_down", cnt[2], 32'(ml[j] == 2'h1));
      rsp(ml[j] == 2'h1 ? 8'h00 : CMD_ROLL);
      if (ml[j] != 2'h1)
        chk("roll", {last.addr, last.frame}, {my_addr, 4'(fr + 1)});
    end
    @(posedge ref_clk);
    mode <= 2'h0;
    run(CMD_ACK, 6'h05, 1'b1, 3'b000, 2);
    chk("rc_mode", rc_mode, 0);
    repeat (60) @(posedge ref_clk);
    #1;
    rsp(CMD_FAIL);
    chk("fail_addr", last.addr, my_addr);
    for (int m = 1; m < 4; m += 2) begin
      @(posedge ref_clk);
      mode <= 2'(m);
      run(CMD_ACK, 6'h05, 1'b1, 3'b000, 60);
      chk("relay_down", cnt[2], 1);
      rsp(8'h00);
    end
    @(posedge ref_clk);
    {mode, my_addr} <= {2'h0, 6'h05};
    run(CMD_ACK, 6'h1F, 1'b1, 3'b000, 60);
    chk("top_dev", top_dev, 1);
    rsp(CMD_ACK);
    repeat (16) begin
      @(posedge ref_clk);
      a = 6'($urandom);
      my_addr <= a;
      stack_size <= $urandom_range(0, 1) ? a : 6'($urandom);
      repeat (2) @(posedge ref_clk);
      #1;
      chk("top_dev", top_dev, 32'(my_addr == stack_size));
    end
    run(CMD_SOFT, ADDR_ALL, 1'b1, 3'b000, PC - 5);
    chk("regs_default", cnt[5], 1);
    chk("scan_stop", cnt[6], 1);
    chk("self_reset", cnt[7], 0);
    repeat (15) @(posedge ref_clk);
    #1;
    chk("self_reset", cnt[7], 1);
    rsp(8'h00);
    for (int c = 0; c < 2; c++) begin
      run(c ? CMD_CKCMP : CMD_CKSET, ADDR_ALL, 1'b1, 3'b000, 60);
      chk("cksum_calc", cnt[8], 32'(c == 0));
      chk("cksum_check", cnt[9], 32'(c == 1));
    end
    for (int i = 0; i < 8; i++) begin
      if (i[0]) begin
        run(CMD_OVR, ADDR_ALL, 1'b1, 3'b000, 60);
        chk("ovr_armed", ovr_armed, 1);
      end
      o = 16'($urandom);
      d = (i < 2) ? 16'hFFFF : 16'($urandom);
      @(posedge ref_clk);
      {fw_commit, fw_old, fw_data} <= {1'b1, o, d};
      @(posedge ref_clk);
      fw_commit <= 1'b0;
      #1;
      chk("fw_new", fw_new, fexp(i[0], o, d));
      chk("ovr_clear", ovr_armed, 0);
    end
    stop_test;
  end

  // Cuts a hang short after well beyond the expected run length.
  initial begin
    repeat (80000) @(posedge ref_clk);
    miscompares++;
    stop_test;
  end
endmodule
`default_nettype wire
